// >>> verilog/tw_channel.sv
// two-wire channel with hardware master and full slave
`timescale 1ns/10ps
//Contract
//(RULE1) channel has master and full slave
//(RULE2) no repeated start; stop ends transfer
//(RULE3) clock and data driven open drain
//(RULE4) slave answers four programmable addresses
//(RULE5) software changes ids only when idle
//(RULE6) start on idle bus, address, data, stop
//(RULE7) master or slave, never both
//(RULE8) divider covers 100 kHz and 400 kHz
//(RULE9) period is (2+high)+(2+low) core cycles
//(RULE10) divider upper byte high, lower low
//(RULE11) software picks divider values for speed
//(RULE12) seven upper address bits must match
//(RULE13) stored id bit zero ignored
//(RULE14) read count is bytes minus one
//(RULE15) empty transmit holding sends target address
//(RULE16) broadcast byte goes first, bypasses queue
//(RULE17) after broadcast wait for next write
//(RULE18) general call id recognised by slave
//(RULE19) separate status, receive, transmit per side
//(RULE20) master and slave own interrupt lines
//(RULE21) master nacks last read byte
module tw_channel
	import tw_pkg::*;
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	// bus pins
	input  wire logic        scl_in_i,
	output logic             scl_out_o,
	output logic             scl_oe_o,
	input  wire logic        sda_in_i,
	output logic             sda_out_o,
	output logic             sda_oe_o,
	// master control
	input  wire logic        master_enable_i,
	input  wire logic [15:0] bus_clock_divider_i,
	input  wire logic [2:0]  master_read_count_i,
	input  wire logic [7:0]  master_target_address_i,
	input  wire logic        master_target_address_wr_i,
	input  wire logic [7:0]  broadcast_lead_byte_i,
	input  wire logic        broadcast_lead_byte_wr_i,
	input  wire logic [7:0]  master_transmit_holding_i,
	input  wire logic        master_transmit_wr_i,
	input  wire logic        master_receive_rd_i,
	input  wire logic        master_status_clear_i,
	// master results
	output logic [7:0]       master_receive_holding_o,
	output logic [7:0]       master_status_flags_o,
	output logic             master_irq_o,
	// slave control
	input  wire logic        slave_enable_i,
	input  wire logic [7:0]  slave_match_address_a_i,
	input  wire logic [7:0]  slave_match_address_b_i,
	input  wire logic [7:0]  slave_match_address_c_i,
	input  wire logic [7:0]  slave_match_address_d_i,
	input  wire logic [7:0]  general_call_match_id_i,
	input  wire logic [7:0]  slave_transmit_holding_i,
	input  wire logic        slave_transmit_wr_i,
	input  wire logic        slave_receive_rd_i,
	input  wire logic        slave_status_clear_i,
	// slave results
	output logic [7:0]       slave_receive_holding_o,
	output logic [7:0]       slave_status_flags_o,
	output logic             slave_irq_o
);
	tw_mstate_t  m_state;
	tw_sstate_t  s_state;
	tw_kind_t    m_kind;
	logic [1:0]  scl_sy;
	logic [1:0]  sda_sy;
	logic        scl_q;
	logic        sda_q;
	logic        scl_s;
	logic        sda_s;
	logic        bus_busy;
	logic        m_scl_low;
	logic        m_fall;
	logic        m_hi_end;
	logic        m_run;
	logic        m_sda_low;
	logic        m_stop_next;
	logic        m_read;
	logic        m_pend;
	logic        en_q;
	logic [2:0]  m_bit;
	logic [2:0]  m_rcnt;
	logic [7:0]  m_sh;
	logic [7:0]  mtx;
	logic        mtx_valid;
	logic [7:0]  bcast;
	logic        bcast_valid;
	logic        adr_new;
	logic [7:0]  m_flags;
	logic        s_sda_low;
	logic [3:0]  s_bit;
	logic [7:0]  s_sh;
	logic [7:0]  stx;
	logic        stx_valid;
	logic        s_dir_rd;
	logic        s_nacked;
	logic [7:0]  s_flags;
	logic        s_match;
	logic        s_gc;
	logic        start_seen;
	logic        stop_seen;
	logic        scl_rise;
	logic        scl_fall;
	logic        m_active;

	// pin synchronisers; first stage feeds only the second
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			scl_sy <= 2'h3;
			sda_sy <= 2'h3;
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
		end
		else
		begin
			scl_sy <= {scl_sy[0], scl_in_i};
			sda_sy <= {sda_sy[0], sda_in_i};
			scl_q  <= scl_sy[1];
			sda_q  <= sda_sy[1];
		end
	end

	assign scl_s      = scl_sy[1];
	assign sda_s      = sda_sy[1];
	assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_seen  = scl_s & scl_q & ~sda_q & sda_s;
	assign scl_rise   = scl_s & ~scl_q;
	assign scl_fall   = ~scl_s & scl_q;
	assign m_active   = (m_state != M_IDLE);

	// bus ownership tracked from start and stop
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			bus_busy <= 1'b0;
		else if (start_seen)
			bus_busy <= 1'b1;
		else if (stop_seen)
			bus_busy <= 1'b0;
	end

	// (RULE9) clock run stops once stop is placed
	assign m_run = m_active && !(m_state == M_STOP && m_hi_end);

	// (RULE8) (RULE10) upper byte high count
	tw_sclgen #(
		.CW(8)
	) u_sclgen (
		.mclk_i       (mclk_i),
		.reset_n_i    (reset_n_i),
		.run_i        (m_run),
		.hold_i       (m_state == M_WAIT),
		.high_count_i (bus_clock_divider_i[DIV_HIGH_MSB:DIV_HIGH_LSB]),
		.low_count_i  (bus_clock_divider_i[DIV_LOW_MSB:DIV_LOW_LSB]),
		.scl_low_o    (m_scl_low),
		.fall_o       (m_fall),
		.hi_end_o     (m_hi_end)
	);

	// (RULE4) four ids plus general call
	tw_addr_match u_match (
		.addr_byte_i (s_sh),
		.id_a_i      (slave_match_address_a_i),
		.id_b_i      (slave_match_address_b_i),
		.id_c_i      (slave_match_address_c_i),
		.id_d_i      (slave_match_address_d_i),
		.gc_id_i     (general_call_match_id_i),
		.match_o     (s_match),
		.gc_o        (s_gc)
	);

	// software-written holding bytes; consumption wins only without a write
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mtx <= BYTE_RESET;
			mtx_valid <= 1'b0;
			bcast <= BYTE_RESET;
			bcast_valid <= 1'b0;
			adr_new <= 1'b0;
			en_q <= 1'b0;
			m_pend <= 1'b0;
		end
		else
		begin
			en_q <= master_enable_i;
			if (master_transmit_wr_i)
			begin
				mtx <= master_transmit_holding_i;
				mtx_valid <= 1'b1;
			end
			else if (m_fall && m_sh == mtx && m_kind != K_BCAST && m_bit == 3'h0
				&& m_state == M_SEND && mtx_valid)
				mtx_valid <= 1'b0;
			// (RULE16) broadcast byte bypasses the queue
			if (broadcast_lead_byte_wr_i)
			begin
				bcast <= broadcast_lead_byte_i;
				bcast_valid <= 1'b1;
			end
			else if (m_state == M_START || m_state == M_WAIT)
				bcast_valid <= 1'b0;
			if (master_target_address_wr_i)
				adr_new <= 1'b1;
			else if (m_state == M_WAIT || m_state == M_START)
				adr_new <= 1'b0;
			if (master_enable_i && !en_q)
				m_pend <= 1'b1;
			else if (m_state == M_START || !master_enable_i)
				m_pend <= 1'b0;
		end
	end

	// (RULE1) master half of the channel
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			m_state <= M_IDLE;
			m_kind <= K_ADDR;
			m_sda_low <= 1'b0;
			m_stop_next <= 1'b0;
			m_read <= 1'b0;
			m_bit <= 3'h0;
			m_rcnt <= COUNT_RESET;
			m_sh <= BYTE_RESET;
			master_receive_holding_o <= BYTE_RESET;
			m_flags <= '0;
		end
		else
		begin
			// sticky flags: a new event beats the clear
			if (master_status_clear_i)
				m_flags[MST_DONE:MST_NACK_ADDR] <= '0;
			if (master_receive_rd_i)
				m_flags[MST_RX_READY] <= 1'b0;
			case (m_state)
				M_IDLE:
				begin
					m_stop_next <= 1'b0;
					// (RULE7) no start while slave is addressed
					if (m_pend && !bus_busy && scl_s && sda_s
						&& s_state == S_IDLE)
					begin
						// (RULE6) start on an idle bus
						m_state <= M_START;
						m_sda_low <= 1'b1;
						m_rcnt <= master_read_count_i;
						if (bcast_valid)
						begin
							m_sh <= bcast;
							m_kind <= K_BCAST;
						end
						// (RULE15) address when holding is empty
						else
						begin
							m_sh <= mtx_valid ? mtx : master_target_address_i;
							m_read <= mtx_valid ? mtx[0]
								: master_target_address_i[0];
							m_kind <= K_ADDR;
						end
					end
				end
				M_START:
					if (m_fall)
					begin
						m_state <= M_SEND;
						m_bit <= 3'h0;
						m_sda_low <= ~m_sh[7];
					end
				M_SEND:
					// (RULE3) released one read back low
					if (m_hi_end && !m_sda_low && !sda_s)
					begin
						m_state <= M_IDLE;
						m_sda_low <= 1'b0;
						m_flags[MST_ARB_LOST] <= 1'b1;
					end
					else if (m_fall)
						if (m_bit == 3'h7)
						begin
							m_state <= M_SACK;
							m_sda_low <= 1'b0;
						end
						else
						begin
							m_bit <= m_bit + 3'h1;
							m_sh <= {m_sh[6:0], 1'b0};
							m_sda_low <= ~m_sh[6];
						end
				M_SACK:
					if (m_hi_end && sda_s)
					begin
						m_stop_next <= 1'b1;
						if (m_kind == K_DATA)
							m_flags[MST_NACK_DATA] <= 1'b1;
						else
							m_flags[MST_NACK_ADDR] <= 1'b1;
					end
					else if (m_fall)
					begin
						m_bit <= 3'h0;
						if (m_stop_next)
						begin
							m_state <= M_STOP;
							m_sda_low <= 1'b1;
						end
						// (RULE17) hold clock low after broadcast
						else if (m_kind == K_BCAST)
							m_state <= M_WAIT;
						else if (m_read)
							m_state <= M_RECV;
						else if (mtx_valid)
						begin
							m_state <= M_SEND;
							m_kind <= K_DATA;
							m_sh <= mtx;
							m_sda_low <= ~mtx[7];
						end
						// (RULE2) always a stop, never a restart
						else
						begin
							m_state <= M_STOP;
							m_sda_low <= 1'b1;
						end
					end
				M_WAIT:
					if (bcast_valid || adr_new)
					begin
						m_state <= M_SEND;
						m_kind <= bcast_valid ? K_BCAST : K_ADDR;
						m_sh <= bcast_valid ? bcast : master_target_address_i;
						m_read <= master_target_address_i[0];
						m_sda_low <= bcast_valid ? ~bcast[7]
							: ~master_target_address_i[7];
					end
				M_RECV:
				begin
					if (m_hi_end)
						m_sh <= {m_sh[6:0], sda_s};
					if (m_fall)
						if (m_bit == 3'h7)
						begin
							// (RULE21) last byte left without ack
							m_state <= M_RACK;
							m_sda_low <= (m_rcnt != 3'h0);
							master_receive_holding_o <= m_sh;
							m_flags[MST_RX_READY] <= 1'b1;
						end
						else
							m_bit <= m_bit + 3'h1;
				end
				M_RACK:
					if (m_fall)
					begin
						m_bit <= 3'h0;
						// (RULE14) count plus one bytes read
						if (m_rcnt == 3'h0)
						begin
							m_state <= M_STOP;
							m_sda_low <= 1'b1;
						end
						else
						begin
							m_state <= M_RECV;
							m_rcnt <= m_rcnt - 3'h1;
							m_sda_low <= 1'b0;
						end
					end
				M_STOP:
					if (m_hi_end)
					begin
						m_state <= M_IDLE;
						m_sda_low <= 1'b0;
						m_flags[MST_DONE] <= 1'b1;
					end
				default:
				begin
					m_state <= M_IDLE;
					m_sda_low <= 1'b0;
				end
			endcase
		end
	end

	// slave sequencer; idle whenever the master owns the channel
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s_state <= S_IDLE;
			s_sda_low <= 1'b0;
			s_bit <= 4'h0;
			s_sh <= BYTE_RESET;
			s_dir_rd <= 1'b0;
			s_nacked <= 1'b0;
			stx <= BYTE_RESET;
			stx_valid <= 1'b0;
			slave_receive_holding_o <= BYTE_RESET;
			s_flags <= '0;
		end
		else
		begin
			if (slave_status_clear_i)
				s_flags[SST_OVERRUN:SST_GC_HIT] <= '0;
			if (slave_receive_rd_i)
				s_flags[SST_RX_READY] <= 1'b0;
			if (slave_transmit_wr_i)
			begin
				stx <= slave_transmit_holding_i;
				stx_valid <= 1'b1;
			end
			if (scl_rise)
				s_bit <= s_bit + 4'h1;
			// (RULE7) slave off while master is active
			if (!slave_enable_i || m_active)
			begin
				s_state <= S_IDLE;
				s_sda_low <= 1'b0;
			end
			else if (start_seen)
			begin
				s_state <= S_ADDR;
				s_bit <= 4'h0;
				s_sda_low <= 1'b0;
			end
			else if (stop_seen)
			begin
				if (s_state != S_IDLE && s_state != S_ADDR)
					s_flags[SST_STOP] <= 1'b1;
				s_state <= S_IDLE;
				s_sda_low <= 1'b0;
			end
			else
				case (s_state)
					S_IDLE:
						s_sda_low <= 1'b0;
					S_ADDR, S_RX:
					begin
						if (scl_rise)
							s_sh <= {s_sh[6:0], sda_s};
						if (scl_fall && s_bit == 4'h8)
						begin
							s_bit <= 4'h0;
							if (s_state == S_RX)
							begin
								s_state <= S_RACK;
								s_sda_low <= 1'b1;
								slave_receive_holding_o <= s_sh;
								s_flags[SST_RX_READY] <= 1'b1;
								if (s_flags[SST_RX_READY] && !slave_receive_rd_i)
									s_flags[SST_OVERRUN] <= 1'b1;
							end
							// (RULE18) general call id also answered
							else if (s_match)
							begin
								s_state <= S_AACK;
								s_sda_low <= 1'b1;
								s_dir_rd <= s_sh[0];
								if (s_gc)
									s_flags[SST_GC_HIT] <= 1'b1;
							end
							else
								s_state <= S_IDLE;
						end
					end
					S_AACK, S_RACK, S_TACK:
					begin
						if (scl_rise && s_state == S_TACK)
							s_nacked <= sda_s;
						if (scl_fall)
						begin
							s_bit <= 4'h0;
							if (s_state == S_TACK && s_nacked)
							begin
								s_state <= S_IDLE;
								s_sda_low <= 1'b0;
							end
							else if (s_state == S_RACK
								|| (s_state == S_AACK && !s_dir_rd))
							begin
								s_state <= S_RX;
								s_sda_low <= 1'b0;
							end
							else
							begin
								// empty holding sends an idle byte
								s_state <= S_TX;
								s_sh <= stx_valid ? stx : IDLE_BYTE;
								s_sda_low <= stx_valid ? ~stx[7] : 1'b0;
								if (!stx_valid)
									s_flags[SST_UNDERRUN] <= 1'b1;
								if (!slave_transmit_wr_i)
									stx_valid <= 1'b0;
							end
						end
					end
					S_TX:
						if (scl_fall)
							if (s_bit == 4'h8)
							begin
								s_state <= S_TACK;
								s_sda_low <= 1'b0;
							end
							else
							begin
								s_sh <= {s_sh[6:0], 1'b0};
								s_sda_low <= ~s_sh[6];
							end
					default:
					begin
						s_state <= S_IDLE;
						s_sda_low <= 1'b0;
					end
				endcase
		end
	end

	// (RULE3) pins only ever pulled low
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			scl_out_o <= 1'b0;
			sda_out_o <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end
		else
		begin
			scl_out_o <= 1'b0;
			sda_out_o <= 1'b0;
			scl_oe_o <= m_scl_low;
			sda_oe_o <= m_sda_low | s_sda_low;
		end
	end

	// (RULE19) separate status per side
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			master_status_flags_o <= '0;
			slave_status_flags_o <= '0;
			master_irq_o <= 1'b0;
			slave_irq_o <= 1'b0;
		end
		else
		begin
			master_status_flags_o <= {m_state == M_WAIT,
				m_flags[MST_DONE:MST_RX_READY], ~mtx_valid, m_active};
			slave_status_flags_o <= {s_flags[SST_OVERRUN:SST_GC_HIT],
				s_dir_rd, s_flags[SST_RX_READY], ~stx_valid,
				s_state != S_IDLE && s_state != S_ADDR};
			// (RULE20) one interrupt line per side
			master_irq_o <= |m_flags[MST_DONE:MST_RX_READY]
				| (m_state == M_WAIT);
			slave_irq_o <= |s_flags[SST_OVERRUN:SST_GC_HIT]
				| s_flags[SST_RX_READY];
		end
	end
endmodule

// >>> verilog/tw_pkg.sv
// shared constants and types of the two-wire channel
package tw_pkg;
	// divider layout and clock period overhead
	localparam int DIV_HIGH_MSB = 15;
	localparam int DIV_HIGH_LSB = 8;
	localparam int DIV_LOW_MSB  = 7;
	localparam int DIV_LOW_LSB  = 0;
	localparam int SCL_OVERHEAD = 2;
	// suggested divider settings for software
	localparam logic [15:0] DIV_STD_100K  = 16'hCFCF;
	localparam logic [15:0] DIV_FAST_400K = 16'h283C;
	// reset values and the idle byte sent on an empty slave holding
	localparam logic [7:0] BYTE_RESET  = 8'h00;
	localparam logic [2:0] COUNT_RESET = 3'h0;
	localparam logic [7:0] IDLE_BYTE   = 8'hFF;
	// master status bit positions
	localparam int MST_BUSY      = 0;
	localparam int MST_TX_REQ    = 1;
	localparam int MST_RX_READY  = 2;
	localparam int MST_NACK_ADDR = 3;
	localparam int MST_NACK_DATA = 4;
	localparam int MST_ARB_LOST  = 5;
	localparam int MST_DONE      = 6;
	localparam int MST_BC_WAIT   = 7;
	// slave status bit positions
	localparam int SST_BUSY     = 0;
	localparam int SST_TX_REQ   = 1;
	localparam int SST_RX_READY = 2;
	localparam int SST_DIR_READ = 3;
	localparam int SST_GC_HIT   = 4;
	localparam int SST_STOP     = 5;
	localparam int SST_UNDERRUN = 6;
	localparam int SST_OVERRUN  = 7;
	// master and slave sequencer states
	typedef enum logic [2:0] {
		M_IDLE  = 3'h0,
		M_START = 3'h1,
		M_SEND  = 3'h3,
		M_SACK  = 3'h2,
		M_RECV  = 3'h6,
		M_RACK  = 3'h7,
		M_STOP  = 3'h5,
		M_WAIT  = 3'h4
	} tw_mstate_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_ADDR = 3'h1,
		S_AACK = 3'h3,
		S_RX   = 3'h2,
		S_RACK = 3'h6,
		S_TX   = 3'h7,
		S_TACK = 3'h5
	} tw_sstate_t;
	// byte kinds sent by the master
	typedef enum logic [1:0] {
		K_BCAST = 2'h0,
		K_ADDR  = 2'h1,
		K_DATA  = 2'h3
	} tw_kind_t;
endpackage

// >>> verilog/tw_sclgen.sv
// master serial clock generator with high and low counts
`timescale 1ns/10ps
module tw_sclgen
	import tw_pkg::*;
#(
	parameter int CW = 8
)(
	// clock and reset
	input  wire logic          mclk_i,
	input  wire logic          reset_n_i,
	// control
	input  wire logic          run_i,
	input  wire logic          hold_i,
	input  wire logic [CW-1:0] high_count_i,
	input  wire logic [CW-1:0] low_count_i,
	// clock state and phase pulses
	output logic               scl_low_o,
	output logic               fall_o,
	output logic               hi_end_o
);
	logic [CW:0] cnt;
	logic [CW:0] hi_last;
	logic [CW:0] lo_last;

	// (RULE9) phases of two plus count
	assign hi_last = (CW+1)'(high_count_i) + (CW+1)'(SCL_OVERHEAD - 1);
	assign lo_last = (CW+1)'(low_count_i) + (CW+1)'(SCL_OVERHEAD - 1);

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			scl_low_o <= 1'b0;
			fall_o    <= 1'b0;
			hi_end_o  <= 1'b0;
			cnt       <= '0;
		end
		else
		begin
			fall_o   <= 1'b0;
			hi_end_o <= 1'b0;
			if (!run_i)
			begin
				scl_low_o <= 1'b0;
				cnt       <= '0;
			end
			else if (!scl_low_o)
			begin
				// pulse marks the last high cycle
				if (cnt == hi_last - (CW+1)'(1) || hi_last == '0)
					hi_end_o <= (cnt != hi_last);
				if (cnt == hi_last)
				begin
					scl_low_o <= 1'b1;
					fall_o    <= 1'b1;
					cnt       <= '0;
				end
				else
					cnt <= cnt + (CW+1)'(1);
			end
			// hold stretches the low phase while waiting
			else if (!hold_i)
			begin
				if (cnt == lo_last)
				begin
					scl_low_o <= 1'b0;
					cnt       <= '0;
				end
				else
					cnt <= cnt + (CW+1)'(1);
			end
		end
	end
endmodule

// >>> verilog/tw_addr_match.sv
// slave address compare against four ids and general call
`timescale 1ns/10ps
module tw_addr_match
	import tw_pkg::*;
(
	// received byte and stored ids
	input  wire logic [7:0] addr_byte_i,
	input  wire logic [7:0] id_a_i,
	input  wire logic [7:0] id_b_i,
	input  wire logic [7:0] id_c_i,
	input  wire logic [7:0] id_d_i,
	input  wire logic [7:0] gc_id_i,
	// results
	output logic            match_o,
	output logic            gc_o
);
	// (RULE13) direction bit left out
	function automatic logic same7(input logic [7:0] a, input logic [7:0] b);
		return a[7:1] == b[7:1];
	endfunction

	// (RULE12) any of four ids or the general call id
	assign gc_o    = same7(addr_byte_i, gc_id_i);
	assign match_o = same7(addr_byte_i, id_a_i) | same7(addr_byte_i, id_b_i)
		| same7(addr_byte_i, id_c_i) | same7(addr_byte_i, id_d_i) | gc_o;
endmodule

// >>> dv/tw_channel_properties.sv
// port assertions for the two-wire channel
`timescale 1ns/10ps
module tw_channel_chk
	import tw_pkg::*;
(
	// clock, reset and bus pins
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	input  wire logic        scl_in_i,
	input  wire logic        sda_in_i,
	input  wire logic        scl_out_o,
	input  wire logic        scl_oe_o,
	input  wire logic        sda_out_o,
	input  wire logic        sda_oe_o,
	// control and status
	input  wire logic [15:0] bus_clock_divider_i,
	input  wire logic [7:0]  master_status_flags_o,
	input  wire logic        master_irq_o,
	input  wire logic [7:0]  slave_status_flags_o,
	input  wire logic        slave_irq_o
);
	logic        oe_q;
	logic        sda_q;
	logic        in_frame;
	logic [15:0] run_len;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);

	// saturates so long idle stretches cannot wrap
	always_ff @(posedge mclk_i or negedge reset_n_i)
		if (!reset_n_i)
		begin
			oe_q     <= 1'b0;
			sda_q    <= 1'b1;
			run_len  <= 16'h0001;
			in_frame <= 1'b0;
		end
		else
		begin
			oe_q  <= scl_oe_o;
			sda_q <= sda_in_i;
			if (scl_oe_o != oe_q)
				run_len <= 16'h0001;
			else if (run_len != 16'hFFFF)
				run_len <= run_len + 16'h0001;
			if (scl_in_i && sda_q != sda_in_i)
				in_frame <= sda_q;
		end

	a_pins_low: assert property (!scl_out_o && !sda_out_o)
		else $error("pin data not held low");
	a_mirq_sum: assert property (
		master_irq_o == |master_status_flags_o[7:2])
		else $error("master irq not status sum");
	a_sirq_sum: assert property (
		slave_irq_o == |{slave_status_flags_o[7:4],
		slave_status_flags_o[2]})
		else $error("slave irq not status sum");
	a_one_role: assert property (
		!(master_status_flags_o[MST_BUSY] && slave_status_flags_o[SST_BUSY]))
		else $error("master and slave busy together");
	a_high_len: assert property ($rose(scl_oe_o) |-> run_len >=
		16'(bus_clock_divider_i[DIV_HIGH_MSB:DIV_HIGH_LSB]) + 16'h0002)
		else $error("clock high phase short");
	a_low_len: assert property ($fell(scl_oe_o) |-> run_len >=
		16'(bus_clock_divider_i[DIV_LOW_MSB:DIV_LOW_LSB]) + 16'h0002)
		else $error("clock low phase short");
	a_no_restart: assert property (
		$rose(sda_oe_o) && scl_in_i && !scl_oe_o |-> !in_frame)
		else $error("start issued inside a frame");
	a_stop_idle: assert property (
		$rose(master_status_flags_o[MST_DONE]) |-> scl_in_i && sda_in_i)
		else $error("done flagged with bus not idle");
endmodule

bind tw_channel tw_channel_chk i_chk (
	.mclk_i, .reset_n_i, .scl_in_i, .sda_in_i, .scl_out_o, .scl_oe_o,
	.sda_out_o, .sda_oe_o, .bus_clock_divider_i, .master_status_flags_o,
	.master_irq_o, .slave_status_flags_o, .slave_irq_o
);

// >>> dv/tw_slave_model.sv
// behavioural far-side slave device on the shared bus
`timescale 1ns/10ps
module tw_slave_model #(
	parameter logic [6:0] ADDR = 7'h2A
)(
	// bus lines, pulled up outside
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_low_o,
	// first byte returned on reads
	input  wire logic [7:0] rd_base_i
);
	logic [7:0] log_q[$];
	logic       ack_q[$];

	task automatic get(output logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge scl_i);
			b = {b[6:0], sda_i};
		end
	endtask

	// leaves the line low; caller decides the next level
	task automatic ack();
		@(negedge scl_i);
		#13 sda_low_o = 1'b1;
		@(negedge scl_i);
		#13;
	endtask

	task automatic frame();
		logic [7:0] b;
		logic [7:0] d;
		get(b);
		log_q.push_back(b);
		if (b[7:1] != ADDR && b != 8'h00)
			return;
		ack();
		d = rd_base_i;
		forever
			if (b[0] && b[7:1] == ADDR)
			begin
				for (int i = 7; i >= 0; i--)
				begin
					sda_low_o = !d[i];
					@(negedge scl_i);
					#13;
				end
				sda_low_o = 1'b0;
				@(posedge scl_i);
				ack_q.push_back(sda_i);
				// nack frees the line for stop
				if (sda_i)
					return;
				d = d + 8'h01;
				@(negedge scl_i);
				#13;
			end
			else
			begin
				sda_low_o = 1'b0;
				get(d);
				log_q.push_back(d);
				ack();
			end
	endtask

	// frames open at start, end at stop
	initial
	begin
		sda_low_o = 1'b0;
		forever
		begin
			@(negedge sda_i iff scl_i);
			fork
				frame();
				@(posedge sda_i iff scl_i);
			join_any
			disable fork;
			sda_low_o = 1'b0;
		end
	end
endmodule

// >>> dv/tw_channel_tb.sv
// self-checking bench for the two-wire channel
`timescale 1ns/10ps
module tw_channel_tb import tw_pkg::*;;
	localparam logic [6:0] PA = 7'h2A;
	logic        clk, rst_n, tsc, tsd, scl, sda, psd;
	logic        soe, doe, sout, dout, men, sen, mirq, sirq;
	logic [15:0] div;
	logic [2:0]  cnt;
	logic [7:0]  adr, bcb, mtx, stx, base, mrx, msta, srx, ssta, wr;
	logic [7:0]  id [5];
	int          n_fail, tests_run;

	// wired-and lines with pull-ups
	assign scl = !(soe || tsc);
	assign sda = !(doe || psd || tsd);

	tw_channel i_dut (
		.mclk_i(clk), .reset_n_i(rst_n), .scl_in_i(scl),
		.scl_out_o(sout), .scl_oe_o(soe), .sda_in_i(sda),
		.sda_out_o(dout), .sda_oe_o(doe), .master_enable_i(men),
		.bus_clock_divider_i(div), .master_read_count_i(cnt),
		.master_target_address_i(adr),
		.master_target_address_wr_i(wr[0]),
		.broadcast_lead_byte_i(bcb), .broadcast_lead_byte_wr_i(wr[1]),
		.master_transmit_holding_i(mtx), .master_transmit_wr_i(wr[2]),
		.master_receive_rd_i(wr[3]), .master_status_clear_i(wr[4]),
		.master_receive_holding_o(mrx), .master_status_flags_o(msta),
		.master_irq_o(mirq), .slave_enable_i(sen),
		.slave_match_address_a_i(id[0]), .slave_match_address_b_i(id[1]),
		.slave_match_address_c_i(id[2]), .slave_match_address_d_i(id[3]),
		.general_call_match_id_i(id[4]), .slave_transmit_holding_i(stx),
		.slave_transmit_wr_i(wr[5]), .slave_receive_rd_i(wr[6]),
		.slave_status_clear_i(wr[7]), .slave_receive_holding_o(srx),
		.slave_status_flags_o(ssta), .slave_irq_o(sirq)
	);
	tw_slave_model #(.ADDR(PA)) i_peer (
		.scl_i(scl), .sda_i(sda), .sda_low_o(psd), .rd_base_i(base)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic results();
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e, string m);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic pulse(input int k);
		@(negedge clk);
		wr[k] = 1'b1;
		@(negedge clk);
		wr[k] = 1'b0;
	endtask

	// index 8 waits for the clock pull instead of a flag
	task automatic wt(input int b);
		int i;
		for (i = 0; i < 20000 && (b == 8 ? soe : msta[b]) !== 1'b1; i++)
			@(negedge clk);
		if (i == 20000)
		begin
			n_fail++;
			results();
		end
	endtask

	task automatic xfer(logic [7:0] a, logic [7:0] d, bit wd);
		i_peer.log_q.delete();
		i_peer.ack_q.delete();
		adr = a;
		pulse(0);
		pulse(4);
		tick(2);
		men = 1'b1;
		// holding loaded late so the address goes first
		if (wd)
		begin
			wt(8);
			mtx = d;
			pulse(2);
		end
		wt(MST_DONE);
		men = 1'b0;
	endtask

	task automatic t_read(input logic [2:0] c);
		cnt = c;
		base = 8'h40 + 8'(c);
		xfer({PA, 1'b1}, 8'h00, 1'b0);
		chk(8'(i_peer.ack_q.size()), 8'(c) + 8'h01, "rd len");
		for (int i = 0; i <= c; i++)
			chk(8'(i_peer.ack_q[i]), 8'(i == c), "rd ack");
		chk(mrx, base + 8'(c), "rd last");
		chk(8'(msta[MST_RX_READY]), 8'h01, "rx ready");
		pulse(3);
		tick(2);
		chk(8'(msta[MST_RX_READY]), 8'h00, "rx taken");
	endtask

	task automatic bb(input logic v, output logic a);
		tsd = !v;
		tick(10);
		tsc = 1'b0;
		tick(5);
		a = doe;
		tick(5);
		tsc = 1'b1;
	endtask

	task automatic sbyte(input logic [7:0] b, output logic a);
		for (int i = 7; i >= 0; i--)
			bb(b[i], a);
		bb(1'b1, a);
	endtask

	task automatic t_slave();
		logic [7:0] a [6] = '{8'h20, 8'h30, 8'h45, 8'h66, 8'h00, 8'h40};
		logic       k;
		for (int n = 0; n < 6; n++)
		begin
			pulse(7);
			pulse(6);
			tsd = 1'b1;
			tick(10);
			tsc = 1'b1;
			sbyte(a[n], k);
			chk({7'h00, k}, 8'(n < 5), "slv ack");
			sbyte(8'h50 + 8'(n), k);
			tsd = 1'b1;
			tick(10);
			tsc = 1'b0;
			tick(10);
			tsd = 1'b0;
			tick(10);
			if (n < 5)
				chk(srx, 8'h50 + 8'(n - (n == 2)), "slv data");
			chk({4'h0, ssta[SST_GC_HIT], ssta[SST_DIR_READ],
				ssta[SST_UNDERRUN], sirq}, {4'h0, n == 4, n == 2, n == 2, n < 5},
				"slv st");
		end
	endtask

	initial
	begin
		n_fail = 0;
		tests_run = 0;
		{rst_n, tsc, tsd, men, cnt, adr, bcb, mtx, stx, base, wr} = '0;
		sen = 1'b1;
		// ids set while the bus is idle
		id = '{8'h20, 8'h31, 8'h44, 8'h67, 8'h00};
		div = DIV_FAST_400K;
		tick(4);
		chk(msta, 8'h00, "mst reset");
		chk({6'h00, soe, doe}, 8'h00, "pins reset");
		tick(2);
		rst_n = 1'b1;
		tick(2);
		xfer({PA, 1'b0}, 8'hA5, 1'b1);
		chk(i_peer.log_q[0], {PA, 1'b0}, "wr addr");
		chk(i_peer.log_q[1], 8'hA5, "wr data");
		chk(msta & 8'h38, 8'h00, "wr errs");
		// small counts keep the long reads short
		div = 16'h0203;
		t_read(3'h0);
		t_read(3'h7);
		xfer(8'h22, 8'h00, 1'b0);
		chk(8'(msta[MST_NACK_ADDR]), 8'h01, "adr nack");
		chk(8'(i_peer.log_q.size()), 8'h01, "nack stop");
		i_peer.log_q.delete();
		bcb = 8'h00;
		pulse(1);
		pulse(4);
		tick(2);
		men = 1'b1;
		wt(MST_BC_WAIT);
		tick(60);
		chk({6'h00, soe, mirq}, 8'h03, "bc hold");
		chk(8'(i_peer.log_q.size()), 8'h01, "bc only");
		adr = {PA, 1'b0};
		pulse(0);
		wt(MST_DONE);
		men = 1'b0;
		chk(i_peer.log_q[0], 8'h00, "bc first");
		chk(i_peer.log_q[1], {PA, 1'b0}, "bc addr");
		t_slave();
		results();
	end
endmodule
